// File: verilog/pces_pkg.sv
package pces_pkg;

  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int PARAM_W  = 16;
  localparam int N_PARAM  = 16;
  localparam int IDX_W    = 4;
  localparam int G2_FIRST = 8;
  localparam int OFS_W    = 16;
  localparam int UNIT_W   = 7;
  localparam int CNT_W    = 16;
  localparam int N_IRQ    = 6;

  // Allowed ranges; word 0 of the parameter area is a header, never checked
  localparam logic [PARAM_W-1:0] G1_MAX   = 16'h0FA0;
  localparam logic [PARAM_W-1:0] G2_MAX   = 16'h00FF;
  localparam logic [UNIT_W-1:0]  UNIT_MAX = 7'h5F;

  localparam logic [ADDR_W-1:0] A_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] A_STATUS   = 8'h04;
  localparam logic [ADDR_W-1:0] A_IRQ_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] A_IRQ_MASK = 8'h0C;
  localparam logic [ADDR_W-1:0] A_UNIT     = 8'h10;
  localparam logic [ADDR_W-1:0] A_ERR_OFS  = 8'h14;
  localparam logic [1:0]        PARAM_PAGE = 2'h1;

  localparam int CTRL_RESTART = 0;

  localparam int IRQ_G1   = 0;
  localparam int IRQ_G2   = 1;
  localparam int IRQ_BUS  = 2;
  localparam int IRQ_TMO  = 3;
  localparam int IRQ_WDT  = 4;
  localparam int IRQ_BLK  = 5;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int CLK_MHZ      = 100;
  localparam int HOST_TMO_US  = 100;
  localparam int HOST_TMO_CYC = HOST_TMO_US * CLK_MHZ;
  localparam logic [CNT_W-1:0] SETTLE_CYC = 16'h0004;

  typedef enum logic [2:0] {
    ST_CHECK, ST_RUN, ST_HOLD, ST_UNIT_BLOCK, ST_HOST_BLOCK, ST_HALT
  } pces_state_t;

  typedef struct packed {
    logic bus_check;
    logic heartbeat;
    logic wdt;
    logic unit_dup;
    logic cfg_mismatch;
    logic major_fault;
  } pces_host_t;

  localparam int HOST_W = $bits(pces_host_t);

  typedef logic [N_PARAM-1:0][PARAM_W-1:0] pces_params_t;

  typedef struct packed {
    logic [N_PARAM-1:0] bad;
    logic               g1_bad;
    logic               g2_bad;
    logic               any_bad;
    logic [IDX_W-1:0]   first;
  } pces_chk_t;

endpackage : pces_pkg

// File: verilog/pces_sync.sv
module pces_sync #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d_async,
  output logic      [W-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      logic qb;
      logic next_qb;

      // A change counts only once stages two and three agree
      always_comb begin
        next_qb = (s2 == s3) ? s3 : qb;
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          qb <= 1'b0;
        end else begin
          s1 <= d_async[i];
          s2 <= s1;
          s3 <= s2;
          qb <= next_qb;
        end
      end

      assign q[i] = qb;
    end
  endgenerate

endmodule : pces_sync

// File: verilog/pces_range_chk.sv
module pces_range_chk (
  input  wire pces_pkg::pces_params_t params,
  output pces_pkg::pces_chk_t         result
);

  localparam int IW = pces_pkg::IDX_W;
  localparam int NP = pces_pkg::N_PARAM;
  localparam int G2 = pces_pkg::G2_FIRST;

  logic [NP-1:0] bad;

  genvar i;
  generate
    for (i = 0; i < NP; i++) begin : g_word
      if (i == 0) begin : g_hdr
        assign bad[i] = 1'b0;
      end else if (i < G2) begin : g_grp1
        assign bad[i] = params[i] > pces_pkg::G1_MAX;
      end else begin : g_grp2
        assign bad[i] = params[i] > pces_pkg::G2_MAX;
      end
    end
  endgenerate

  // Lowest offending word offset wins
  always_comb begin
    result         = '0;
    result.bad     = bad;
    result.g1_bad  = |bad[G2-1:0];
    result.g2_bad  = |bad[NP-1:G2];
    result.any_bad = |bad;
    for (int k = NP - 1; k >= 1; k--) begin
      if (bad[k]) begin
        result.first = IW'(k); // [RL3]
      end
    end
  end

endmodule : pces_range_chk

// File: verilog/pces_top.sv
// Overview of operation
// RL1: Bad group-1 write keeps old value, unit lamp lit, run lamp stays lit.
// RL2: Restart with any bad parameter blocks start: unit lamp lit, run off.
// RL3: While start is blocked, offset output shows the bad word offset.
// RL4: Restart with all parameters valid starts normally: unit lamp off, run on.
// RL5: Offset output is zero without errors, else offset of a bad word.
// RL6: Bad group-2 write keeps old values running, unit lamp dark, run lit.
// RL7: In operation offset tracks a bad group-2 word, zero once valid.
// RL8: Host bus transmission error zeroes conversion data, host lamp lit, run lit.
// RL9: Host silent past supervision period: flag it, freeze all outputs.
// RL10: Host watchdog timeout lights host lamp; later state is undefined.
// RL11: Unit number must be unique and 00..95, else no start, host lamp.
// RL12: Host configuration mismatch blocks conversion and flags configuration error.
// RL13: Host major fault at start: host lamp lit, run off, host clears it.
// RL14: Offset zero and both error lamps off until checking completes.
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
module pces_top #(
  parameter int unsigned HOST_TMO_CYCLES = pces_pkg::HOST_TMO_CYC
) (
  input  wire logic                                  aclk,
  input  wire logic                                  aresetn,
  input  wire logic [pces_pkg::ADDR_W-1:0]           s_awaddr,
  input  wire logic                                  s_awvalid,
  output logic                                       s_awready,
  input  wire logic [pces_pkg::DATA_W-1:0]           s_wdata,
  input  wire logic [3:0]                            s_wstrb,
  input  wire logic                                  s_wvalid,
  output logic                                       s_wready,
  output logic [1:0]                                 s_bresp,
  output logic                                       s_bvalid,
  input  wire logic                                  s_bready,
  input  wire logic [pces_pkg::ADDR_W-1:0]           s_araddr,
  input  wire logic                                  s_arvalid,
  output logic                                       s_arready,
  output logic [pces_pkg::DATA_W-1:0]                s_rdata,
  output logic [1:0]                                 s_rresp,
  output logic                                       s_rvalid,
  input  wire logic                                  s_rready,
  input  wire pces_pkg::pces_host_t                  host_in,
  output logic                                       run_lamp,
  output logic                                       unit_error_lamp,
  output logic                                       host_error_lamp,
  output logic [pces_pkg::OFS_W-1:0]                 config_error_offset,
  output logic                                       config_check_error,
  output logic                                       conv_enable,
  output logic                                       conv_zero,
  output pces_pkg::pces_params_t                     active_params,
  output logic                                       irq
);

  localparam logic [pces_pkg::CNT_W-1:0] TMO_LIM =
    pces_pkg::CNT_W'(HOST_TMO_CYCLES - 1);

  pces_pkg::pces_host_t          host;
  pces_pkg::pces_chk_t           chk;
  pces_pkg::pces_params_t        params;
  pces_pkg::pces_params_t        next_params;
  pces_pkg::pces_state_t         state;
  pces_pkg::pces_state_t         next_state;

  logic                          aw_got;
  logic                          next_aw_got;
  logic [pces_pkg::ADDR_W-1:0]   aw_addr;
  logic [pces_pkg::ADDR_W-1:0]   next_aw_addr;
  logic                          w_got;
  logic                          next_w_got;
  logic [pces_pkg::DATA_W-1:0]   w_data;
  logic [pces_pkg::DATA_W-1:0]   next_w_data;
  logic [3:0]                    w_strb;
  logic [3:0]                    next_w_strb;
  logic                          next_awready;
  logic                          next_wready;
  logic                          next_arready;
  logic                          next_bvalid;
  logic [1:0]                    next_bresp;
  logic                          next_rvalid;
  logic [1:0]                    next_rresp;
  logic [pces_pkg::DATA_W-1:0]   next_rdata;
  logic [pces_pkg::UNIT_W-1:0]   unit_number;
  logic [pces_pkg::UNIT_W-1:0]   next_unit_number;
  logic [pces_pkg::N_IRQ-1:0]    irq_stat;
  logic [pces_pkg::N_IRQ-1:0]    next_irq_stat;
  logic [pces_pkg::N_IRQ-1:0]    irq_mask;
  logic [pces_pkg::N_IRQ-1:0]    next_irq_mask;
  logic [pces_pkg::N_IRQ-1:0]    w1c;
  logic [pces_pkg::N_IRQ-1:0]    ev;
  logic                          next_irq;
  logic                          restart_req;
  logic                          next_restart_req;

  logic [pces_pkg::CNT_W-1:0]    cnt;
  logic [pces_pkg::CNT_W-1:0]    next_cnt;
  logic                          next_run;
  logic                          next_erc;
  logic                          next_erh;
  logic [pces_pkg::OFS_W-1:0]    next_ofs;
  logic                          next_cfg;
  logic                          next_conv_en;
  logic                          next_conv_zero;
  pces_pkg::pces_params_t        next_active;
  logic                          g1_q;
  logic                          g2_q;
  logic                          hb_q;
  logic                          start_fault;
  logic [pces_pkg::OFS_W-1:0]    live_ofs;

  pces_sync #(
    .W (pces_pkg::HOST_W)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d_async (host_in),
    .q       (host)
  );

  pces_range_chk u_chk (
    .params (params),
    .result (chk)
  );

  assign start_fault = host.major_fault || host.unit_dup ||
                       (unit_number > pces_pkg::UNIT_MAX);
  assign live_ofs    = chk.any_bad ? pces_pkg::OFS_W'(chk.first) : '0;

  // Register bus: AXI4-Lite slave, parameter area and control registers
  always_comb begin
    next_aw_got      = aw_got;
    next_aw_addr     = aw_addr;
    next_w_got       = w_got;
    next_w_data      = w_data;
    next_w_strb      = w_strb;
    next_bvalid      = s_bvalid;
    next_bresp       = s_bresp;
    next_rvalid      = s_rvalid;
    next_rresp       = s_rresp;
    next_rdata       = s_rdata;
    next_params      = params;
    next_unit_number = unit_number;
    next_irq_mask    = irq_mask;
    next_restart_req = 1'b0;
    w1c              = '0;
    if (s_awvalid && s_awready) begin
      next_aw_got  = 1'b1;
      next_aw_addr = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      next_w_got  = 1'b1;
      next_w_data = s_wdata;
      next_w_strb = s_wstrb;
    end
    if (s_bvalid && s_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_got && w_got && !s_bvalid) begin
      next_aw_got = 1'b0;
      next_w_got  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = pces_pkg::RESP_OKAY;
      if (aw_addr[7:6] == pces_pkg::PARAM_PAGE) begin
        if (w_strb[0]) begin
          next_params[aw_addr[5:2]][7:0] = w_data[7:0];
        end
        if (w_strb[1]) begin
          next_params[aw_addr[5:2]][15:8] = w_data[15:8];
        end
      end else begin
        unique case (aw_addr)
          pces_pkg::A_CTRL: begin
            next_restart_req = w_strb[0] && w_data[pces_pkg::CTRL_RESTART];
          end
          pces_pkg::A_IRQ_STAT: begin
            if (w_strb[0]) begin
              w1c = w_data[pces_pkg::N_IRQ-1:0];
            end
          end
          pces_pkg::A_IRQ_MASK: begin
            if (w_strb[0]) begin
              next_irq_mask = w_data[pces_pkg::N_IRQ-1:0];
            end
          end
          pces_pkg::A_UNIT: begin
            if (w_strb[0]) begin
              next_unit_number = w_data[pces_pkg::UNIT_W-1:0];
            end
          end
          pces_pkg::A_STATUS, pces_pkg::A_ERR_OFS: begin
          end
          default: begin
            next_bresp = pces_pkg::RESP_SLVERR;
          end
        endcase
      end
    end
    if (s_rvalid && s_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_arvalid && s_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = pces_pkg::RESP_OKAY;
      next_rdata  = '0;
      if (s_araddr[7:6] == pces_pkg::PARAM_PAGE) begin
        next_rdata = {16'h0000, params[s_araddr[5:2]]};
      end else begin
        unique case (s_araddr)
          pces_pkg::A_CTRL: begin
          end
          pces_pkg::A_STATUS: begin
            next_rdata = {21'h0, state, 2'h0, conv_enable, conv_zero,
                          config_check_error, host_error_lamp,
                          unit_error_lamp, run_lamp};
          end
          pces_pkg::A_IRQ_STAT: next_rdata = {26'h0, irq_stat};
          pces_pkg::A_IRQ_MASK: next_rdata = {26'h0, irq_mask};
          pces_pkg::A_UNIT:     next_rdata = {25'h0, unit_number};
          pces_pkg::A_ERR_OFS:  next_rdata = {16'h0000, config_error_offset};
          default: begin
            next_rresp = pces_pkg::RESP_SLVERR;
          end
        endcase
      end
    end
    // A new event beats a same-cycle clear
    next_irq_stat = (irq_stat & ~w1c) | ev;
    next_irq      = |(next_irq_stat & next_irq_mask);
    next_awready  = !next_aw_got;
    next_wready   = !next_w_got;
    next_arready  = !next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got      <= 1'b0;
      aw_addr     <= '0;
      w_got       <= 1'b0;
      w_data      <= '0;
      w_strb      <= '0;
      s_awready   <= 1'b0;
      s_wready    <= 1'b0;
      s_arready   <= 1'b0;
      s_bvalid    <= 1'b0;
      s_bresp     <= pces_pkg::RESP_OKAY;
      s_rvalid    <= 1'b0;
      s_rresp     <= pces_pkg::RESP_OKAY;
      s_rdata     <= '0;
      params      <= '0;
      unit_number <= '0;
      irq_stat    <= '0;
      irq_mask    <= '0;
      irq         <= 1'b0;
      restart_req <= 1'b0;
    end else begin
      aw_got      <= next_aw_got;
      aw_addr     <= next_aw_addr;
      w_got       <= next_w_got;
      w_data      <= next_w_data;
      w_strb      <= next_w_strb;
      s_awready   <= next_awready;
      s_wready    <= next_wready;
      s_arready   <= next_arready;
      s_bvalid    <= next_bvalid;
      s_bresp     <= next_bresp;
      s_rvalid    <= next_rvalid;
      s_rresp     <= next_rresp;
      s_rdata     <= next_rdata;
      params      <= next_params;
      unit_number <= next_unit_number;
      irq_stat    <= next_irq_stat;
      irq_mask    <= next_irq_mask;
      irq         <= next_irq;
      restart_req <= next_restart_req;
    end
  end

  // Supervision: start-up check, run, hold and blocked states
  always_comb begin
    next_state     = state;
    next_cnt       = cnt;
    next_run       = run_lamp;
    next_erc       = unit_error_lamp;
    next_erh       = host_error_lamp;
    next_ofs       = config_error_offset;
    next_cfg       = config_check_error;
    next_conv_en   = conv_enable;
    next_conv_zero = conv_zero;
    next_active    = active_params;
    ev             = '0;
    unique case (state)
      pces_pkg::ST_CHECK: begin
        next_run       = 1'b0;
        next_erc       = 1'b0; // [RL14]
        next_erh       = 1'b0; // [RL14]
        next_ofs       = '0; // [RL14]
        next_cfg       = 1'b0;
        next_conv_en   = 1'b0;
        next_conv_zero = 1'b0;
        next_cnt       = cnt + 16'h0001;
        if (cnt == pces_pkg::SETTLE_CYC) begin
          next_cnt = '0;
          if (chk.any_bad) begin
            next_state       = pces_pkg::ST_UNIT_BLOCK; // [RL2]
            next_erc         = 1'b1; // [RL2]
            next_ofs         = live_ofs; // [RL3]
            ev[pces_pkg::IRQ_BLK] = 1'b1;
          end else if (start_fault) begin
            next_state = pces_pkg::ST_HOST_BLOCK; // [RL11] [RL13]
            next_erh   = 1'b1; // [RL11] [RL13]
            ev[pces_pkg::IRQ_BLK] = 1'b1;
          end else if (host.cfg_mismatch) begin
            next_state = pces_pkg::ST_HOST_BLOCK; // [RL12]
            next_erh   = 1'b1;
            next_cfg   = 1'b1; // [RL12]
            ev[pces_pkg::IRQ_BLK] = 1'b1;
          end else begin
            next_state   = pces_pkg::ST_RUN; // [RL4]
            next_run     = 1'b1; // [RL4]
            next_conv_en = 1'b1;
            next_active  = params;
          end
        end
      end
      pces_pkg::ST_RUN: begin
        for (int k = 1; k < pces_pkg::G2_FIRST; k++) begin
          if (!chk.bad[k]) begin
            next_active[k] = params[k]; // [RL1]
          end
        end
        next_erc = chk.g1_bad; // [RL1] [RL6]
        next_ofs = live_ofs; // [RL5] [RL7]
        ev[pces_pkg::IRQ_G1] = chk.g1_bad && !g1_q;
        ev[pces_pkg::IRQ_G2] = chk.g2_bad && !g2_q;
        next_cnt = (host.heartbeat && !hb_q) ? '0 : cnt + 16'h0001;
        if (host.bus_check) begin
          next_conv_zero = 1'b1; // [RL8]
          next_erh       = 1'b1; // [RL8]
          ev[pces_pkg::IRQ_BUS] = 1'b1;
        end
        if (cnt >= TMO_LIM) begin
          next_state = pces_pkg::ST_HOLD; // [RL9]
          next_erh   = 1'b1; // [RL9]
          next_erc   = unit_error_lamp;
          next_ofs   = config_error_offset;
          next_active    = active_params;
          next_conv_zero = conv_zero;
          ev[pces_pkg::IRQ_TMO] = 1'b1;
        end
      end
      pces_pkg::ST_UNIT_BLOCK: begin
        next_ofs = live_ofs; // [RL5]
      end
      pces_pkg::ST_HOLD, pces_pkg::ST_HOST_BLOCK, pces_pkg::ST_HALT: begin
      end
    endcase
    if (host.wdt && state != pces_pkg::ST_HALT) begin
      next_state   = pces_pkg::ST_HALT; // [RL10]
      next_erh     = 1'b1; // [RL10]
      next_run     = 1'b0;
      next_conv_en = 1'b0;
      ev[pces_pkg::IRQ_WDT] = 1'b1;
    end
    if (restart_req) begin
      next_state = pces_pkg::ST_CHECK; // [RL2] [RL4]
      next_cnt   = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state               <= pces_pkg::ST_CHECK;
      cnt                 <= '0;
      run_lamp            <= 1'b0;
      unit_error_lamp     <= 1'b0;
      host_error_lamp     <= 1'b0;
      config_error_offset <= '0;
      config_check_error  <= 1'b0;
      conv_enable         <= 1'b0;
      conv_zero           <= 1'b0;
      active_params       <= '0;
      g1_q                <= 1'b0;
      g2_q                <= 1'b0;
      hb_q                <= 1'b0;
    end else begin
      state               <= next_state;
      cnt                 <= next_cnt;
      run_lamp            <= next_run;
      unit_error_lamp     <= next_erc;
      host_error_lamp     <= next_erh;
      config_error_offset <= next_ofs;
      config_check_error  <= next_cfg;
      conv_enable         <= next_conv_en;
      conv_zero           <= next_conv_zero;
      active_params       <= next_active;
      g1_q                <= chk.g1_bad;
      g2_q                <= chk.g2_bad;
      hb_q                <= host.heartbeat;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_stay_run;
    state == pces_pkg::ST_RUN && next_state == pces_pkg::ST_RUN;
  endsequence

  sequence s_clean_start;
    state == pces_pkg::ST_CHECK && cnt == pces_pkg::SETTLE_CYC &&
    !chk.any_bad && !start_fault && !host.cfg_mismatch &&
    !host.wdt && !restart_req;
  endsequence

  a_g1_keep_run: // [RL1]
    assert property (s_stay_run and chk.g1_bad |=>
                     unit_error_lamp && run_lamp)
    else $error("group-1 range error did not light unit lamp with run");

  a_block_lamps: // [RL2]
    assert property (state == pces_pkg::ST_UNIT_BLOCK |->
                     unit_error_lamp && !run_lamp && !conv_enable)
    else $error("blocked start shows wrong lamps");

  a_block_offset: // [RL3]
    assert property ($rose(state == pces_pkg::ST_UNIT_BLOCK) |->
                     config_error_offset == $past(live_ofs) &&
                     config_error_offset != '0)
    else $error("blocked start does not report the bad word offset");

  a_start_clean: // [RL4]
    assert property (s_clean_start |=> run_lamp && !unit_error_lamp &&
                     state == pces_pkg::ST_RUN)
    else $error("clean start did not reach run");

  a_ofs_zero: // [RL5]
    assert property (s_stay_run and !chk.any_bad |=>
                     config_error_offset == '0)
    else $error("offset not zero without parameter errors");

  a_g2_dark: // [RL6]
    assert property (s_stay_run and (chk.g2_bad && !chk.g1_bad) |=>
                     !unit_error_lamp && run_lamp &&
                     $stable(active_params[pces_pkg::N_PARAM-1:
                                           pces_pkg::G2_FIRST]))
    else $error("group-2 range error changed lamps or values");

  a_ofs_track: // [RL7]
    assert property (s_stay_run |=> config_error_offset == $past(live_ofs))
    else $error("offset does not follow the bad word in operation");

  a_bus_zero: // [RL8]
    assert property (s_stay_run and host.bus_check |=>
                     conv_zero && host_error_lamp && run_lamp)
    else $error("bus check error handling wrong");

  a_tmo_hold: // [RL9]
    assert property (state == pces_pkg::ST_HOLD &&
                     next_state == pces_pkg::ST_HOLD |=>
                     $stable(active_params) && $stable(config_error_offset)
                     && host_error_lamp && $stable(run_lamp))
    else $error("outputs moved while host is silent");

  a_wdt_halt: // [RL10]
    assert property (host.wdt && state != pces_pkg::ST_HALT && !restart_req
                     |=> state == pces_pkg::ST_HALT && host_error_lamp)
    else $error("watchdog error not flagged");

  a_host_block: // [RL11] [RL12] [RL13]
    assert property ($rose(state == pces_pkg::ST_HOST_BLOCK) |->
                     host_error_lamp && !run_lamp && !conv_enable)
    else $error("host-side start fault shows wrong lamps");

  a_check_quiet: // [RL14]
    assert property (state == pces_pkg::ST_CHECK &&
                     next_state == pces_pkg::ST_CHECK |=>
                     config_error_offset == '0 && !unit_error_lamp &&
                     !host_error_lamp)
    else $error("error outputs active during parameter check");

endmodule : pces_top

// File: tb/pces_host_model.sv
module pces_host_model (
  input  wire logic                 aclk,
  input  wire logic                 beat_on,
  input  wire pces_pkg::pces_host_t faults,
  output pces_pkg::pces_host_t      host_in
);
  timeunit 1ns / 1ns;
  logic [2:0] cnt = 3'h0;
  always_ff @(posedge aclk) cnt <= cnt + 3'h1;
  assign host_in = faults | {1'b0, beat_on & cnt[2], 4'h0};
endmodule : pces_host_model

// File: tb/testbench.sv
module testbench;
  timeunit 1ns / 1ns;
  logic aclk = 1'b0, aresetn = 1'b0, beat_on = 1'b1, s_awvalid = 1'b0;
  logic s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0, s_rdata;
  logic [3:0] s_wstrb = 4'hF;
  logic [1:0] s_bresp, s_rresp, rr;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq, conv_zero;
  logic run_lamp, unit_error_lamp, host_error_lamp, conv_enable;
  logic config_check_error;
  logic [15:0] config_error_offset;
  pces_pkg::pces_params_t active_params;
  pces_pkg::pces_host_t host_in, faults = '0;
  int n_mismatch = 0, checks_done = 0;
  always #5 aclk = ~aclk;
  pces_top #(.HOST_TMO_CYCLES(20)) u_dut (.*);
  pces_host_model u_host (.aclk, .beat_on, .faults, .host_in);
  task automatic chk(input string nm, input logic [31:0] seen, want);
    checks_done++;
    n_mismatch += int'(seen !== want);
    if (seen !== want) $display("[ERR] %s exp %h got %h", nm, want, seen);
  endtask : chk
  task automatic lamps(input string nm, input logic [18:0] want);
    chk(nm, {run_lamp, unit_error_lamp, host_error_lamp,
             config_error_offset}, want);
  endtask : lamps
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    {s_awaddr, s_wdata} <= {a, d};
    {s_awvalid, s_wvalid, s_bready} <= 3'b111;
    do begin
      @(posedge aclk);
      s_awvalid <= s_awvalid & ~s_awready;
      s_wvalid <= s_wvalid & ~s_wready;
    end while (!s_bvalid);
    rr = s_bresp;
    s_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    s_araddr <= a;
    {s_arvalid, s_rready} <= 2'b11;
    do begin
      @(posedge aclk);
      s_arvalid <= s_arvalid & ~s_arready;
    end while (!s_rvalid);
    {d, rr} = {s_rdata, s_rresp};
    s_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  task automatic restart;
    wr(8'h00, 32'h1);
    repeat (12) @(posedge aclk);
  endtask : restart
  task automatic results;
    $display("checks %0d errors %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  task automatic t_param;
    wr(8'h64, 32'h100);
    repeat (3) @(posedge aclk);
    lamps("g2 bad", {3'b100, 16'h9});
    chk("g2 kept", active_params[9], 32'h0);
    wr(8'h4C, 32'hFA0);
    wr(8'h4C, 32'hFA1);
    repeat (3) @(posedge aclk);
    chk("g1 kept", active_params[3], 32'hFA0);
    lamps("g1 bad", {3'b110, 16'h3});
    restart();
    lamps("blocked", {3'b010, 16'h3});
    wr(8'h4C, 32'h5);
    wr(8'h64, 32'hFF);
    restart();
    lamps("fixed", {3'b100, 16'h0});
    $display("param done");
  endtask : t_param
  task automatic t_unit;
    logic [31:0] d;
    wr(8'h10, 32'h60);
    rd(8'h10, d);
    chk("unit rd", d, 32'h60);
    restart();
    lamps("unit bad", {3'b001, 16'h0});
    rd(8'h04, d);
    chk("status", d, 32'h404);
    wr(8'h10, 32'h5F);
    restart();
    lamps("unit ok", {3'b100, 16'h0});
    $display("unit done");
  endtask : t_unit
  task automatic t_host;
    chk("masked", irq, 1'b0);
    wr(8'h0C, 32'h4);
    for (int i = 0; i < 3; i++) begin
      faults <= pces_pkg::pces_host_t'(6'h1 << i);
      restart();
      lamps("blk", {3'b001, 16'h0});
      chk("cfg", {conv_enable, config_check_error}, {1'b0, i == 1});
    end
    faults <= '0;
    restart();
    faults <= pces_pkg::pces_host_t'(6'h20);
    repeat (8) @(posedge aclk);
    lamps("bus", {3'b101, 16'h0});
    chk("zero irq", {conv_zero, irq}, 2'b11);
    faults <= '0;
    repeat (8) @(posedge aclk);
    wr(8'h08, 32'h4);
    chk("cleared", irq, 1'b0);
    wr(8'h30, 32'h1);
    chk("unmapped", rr, pces_pkg::RESP_SLVERR);
    restart();
    beat_on <= 1'b0;
    repeat (40) @(posedge aclk);
    lamps("quiet", {3'b101, 16'h0});
    faults <= pces_pkg::pces_host_t'(6'h08);
    repeat (8) @(posedge aclk);
    chk("wdt", {run_lamp, host_error_lamp}, 2'b01);
    $display("host done");
  endtask : t_host
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    lamps("reset", 19'h0);
    repeat (12) @(posedge aclk);
    t_param();
    t_unit();
    t_host();
    results();
  end
  initial begin
    #20000 n_mismatch++;
    results();
  end
endmodule : testbench
